// ### hw/pdmm_fetch.sv
// pdmm_fetch: instruction fetch decode with zero fill above implemented memory
`timescale 1ns/1ps
`default_nettype none

module pdmm_fetch #(
    parameter int PROG_KB = pdmm_pkg::PROG_KB_LARGE
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [20:0] pc,
    input  wire logic [15:0] prog_rdata,
    output logic      [19:0] prog_addr,
    output logic      [15:0] instr_q,
    output logic             instr_in_range_q
);

    // fetch bound from size
    // top byte address is derived from the one size choice, so no second limit can drift
    localparam logic [20:0] PROG_LIMIT = 21'(PROG_KB * 1024);

    logic in_range;

    // word address to the flash; byte bit 0 of the pc is dropped
    assign prog_addr = pc[20:1];
    assign in_range  = (pc < PROG_LIMIT);

    // unimplemented program space
    // fetches past the top read all zeros, which run as no-operation
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            instr_q          <= pdmm_pkg::NOP_WORD;
            instr_in_range_q <= 1'b0;
        end
        else
        begin
            instr_q          <= in_range ? prog_rdata : pdmm_pkg::NOP_WORD;
            instr_in_range_q <= in_range;
        end
    end

endmodule : pdmm_fetch
`default_nettype wire

// ### hw/pdmm_memory_map.sv
// pdmm_memory_map: program counter, stack, banked data space and wishbone status
`timescale 1ns/1ps
`default_nettype none

module pdmm_memory_map #(
    parameter int         PROG_KB = pdmm_pkg::PROG_KB_LARGE,
    parameter logic [7:0] SPLIT   = pdmm_pkg::ACCESS_SPLIT
) (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    // wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // program counter control from the core
    input  wire logic               pc_step,
    input  wire logic               pc_load,
    input  wire logic [20:0]        pc_target,
    input  wire logic               stk_pop,
    input  wire logic               wake_irq,
    input  wire logic               wake_high,
    output logic      [20:0]        pc_q,
    // instruction fetch path
    input  wire logic [15:0]        prog_rdata,
    output logic      [19:0]        prog_addr,
    output logic      [15:0]        instr_q,
    output logic                    instr_in_range_q,
    // data access path
    input  wire pdmm_pkg::pdmm_dreq_s dreq,
    output var pdmm_pkg::pdmm_drsp_s drsp_q
);

    localparam int MEM_BYTES = pdmm_pkg::BANK_COUNT * pdmm_pkg::BANK_BYTES;
    localparam logic [11:0] SFR_BASE = {pdmm_pkg::SFR_BANK, SPLIT};

    logic [3:0]  bank_sel_q;
    logic [4:0]  sp_q;
    logic [20:0] stk_q [pdmm_pkg::STK_DEPTH+1];
    logic [7:0]  mem_q [MEM_BYTES];
    logic [1:0]  gie_q;
    logic [1:0]  wake_flag_q;
    logic        ack_q;
    logic [31:0] wb_dat_q;
    logic [11:0] eff_addr;
    logic        is_sfr;
    logic        bank_ok;
    logic        take_irq;
    logic [20:0] vector;
    logic [20:0] tos;
    logic [7:0]  sfr_rdata;
    logic        sfr_hit;
    logic        wb_wr;
    logic [31:0] wb_rdata;

    // fetch runs off its own path, concurrent with data accesses
    pdmm_fetch #(
        .PROG_KB          (PROG_KB)
    ) u_fetch (
        .mclk             (mclk),
        .rst_b            (rst_b),
        .pc               (pc_q),
        .prog_rdata       (prog_rdata),
        .prog_addr        (prog_addr),
        .instr_q          (instr_q),
        .instr_in_range_q (instr_in_range_q)
    );

    // wake handling: which vector, if the global enable for that wake level allows it
    always_comb
    begin
        take_irq = 1'b0;
        vector   = pdmm_pkg::VEC_LOW;
        if (wake_irq)
        begin
            if (wake_high && gie_q[pdmm_pkg::CTRL_GIE_H])
            begin
                take_irq = 1'b1;
                vector   = pdmm_pkg::VEC_HIGH;
            end
            else if (!wake_high && gie_q[pdmm_pkg::CTRL_GIE_L])
            begin
                take_irq = 1'b1;
                vector   = pdmm_pkg::VEC_LOW;
            end
        end
    end

    // program counter; wake beats load, load beats step
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pc_q <= pdmm_pkg::PC_RESET;
        else if (take_irq)
            pc_q <= vector;
        else if (pc_load)
            pc_q <= pc_target;
        else if (stk_pop)
            pc_q <= tos;
        else if (pc_step)
            pc_q <= pc_q + pdmm_pkg::PC_STEP;
    end

    assign tos = stk_q[sp_q];

    // stack pointer advances on an enabled wake
    // a full stack holds its pointer rather than wrap over live entries
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sp_q <= pdmm_pkg::SP_RESET;
        else if (take_irq && sp_q != 5'(pdmm_pkg::STK_DEPTH))
            sp_q <= sp_q + 5'h01;
        else if (!take_irq && !pc_load && stk_pop && sp_q != pdmm_pkg::SP_RESET)
            sp_q <= sp_q - 5'h01;
    end

    // top of stack captures the current pc
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i <= pdmm_pkg::STK_DEPTH; i++)
                stk_q[i] <= pdmm_pkg::PC_RESET;
        end
        else if (take_irq && sp_q != 5'(pdmm_pkg::STK_DEPTH))
            stk_q[sp_q + 5'h01] <= pc_q;
    end

    // effective address for full, access window and banked forms
    always_comb
    begin
        if (dreq.full)
            eff_addr = dreq.addr;
        else if (dreq.access)
            eff_addr = (dreq.addr[7:0] < SPLIT) ? {4'h0, dreq.addr[7:0]}
                                                : {pdmm_pkg::SFR_BANK, dreq.addr[7:0]};
        else
            // bank selector gives the upper nibble
            eff_addr = {bank_sel_q, dreq.addr[7:0]};
    end

    // banks beyond the implemented count are dropped
    assign bank_ok = (32'(eff_addr[11:8]) < pdmm_pkg::IMPL_BANKS);
    assign is_sfr  = (eff_addr >= SFR_BASE);

    // special function register read decode, zero elsewhere
    always_comb
    begin
        sfr_hit   = 1'b1;
        sfr_rdata = 8'h00;
        case (eff_addr)
            pdmm_pkg::SFR_BANK_SEL: sfr_rdata = {4'h0, bank_sel_q};
            pdmm_pkg::SFR_STK_PTR:  sfr_rdata = {3'h0, sp_q};
            pdmm_pkg::SFR_TOS_LOW:  sfr_rdata = tos[7:0];
            pdmm_pkg::SFR_TOS_HIGH: sfr_rdata = tos[15:8];
            pdmm_pkg::SFR_TOS_UPPR: sfr_rdata = {3'h0, tos[20:16]};
            default:                sfr_hit   = 1'b0;
        endcase
    end

    // only four bits exist; the upper nibble of a write is lost
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            bank_sel_q <= pdmm_pkg::BANK_RESET;
        else if (dreq.valid && dreq.we && eff_addr == pdmm_pkg::SFR_BANK_SEL)
            bank_sel_q <= dreq.wdata[3:0];
    end

    // general purpose bytes, one per 12-bit address
    // writes to absent banks are discarded
    always_ff @(posedge mclk)
    begin
        if (dreq.valid && dreq.we && bank_ok && !is_sfr)
            mem_q[eff_addr] <= dreq.wdata;
    end

    // data answer one cycle after the request; done rises even on a miss
    // so the core updates its arithmetic flags as if it had succeeded
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            drsp_q <= '0;
        else
        begin
            drsp_q.done <= dreq.valid;
            if (!dreq.valid || !bank_ok)
            begin
                drsp_q.hit   <= 1'b0;
                drsp_q.rdata <= 8'h00;
            end
            else if (is_sfr)
            begin
                drsp_q.hit   <= sfr_hit;
                drsp_q.rdata <= sfr_rdata;
            end
            else
            begin
                drsp_q.hit   <= 1'b1;
                drsp_q.rdata <= dreq.we ? 8'h00 : mem_q[eff_addr];
            end
        end
    end

    // no EEPROM decode here: it lives behind its own peripheral
    // registers, so no data address ever selects it

    // wishbone write strobe, taken on the edge that raises ack
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

    // global interrupt enables
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            gie_q <= 2'h0;
        else if (wb_wr && wb_adr_i == pdmm_pkg::WB_CTRL && wb_sel_i[0])
            gie_q <= wb_dat_i[1:0];
    end

    // sticky wake cause; a new wake wins over a clear
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            wake_flag_q <= 2'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (take_irq && (wake_high == (i == pdmm_pkg::WAKE_HIGH)))
                    wake_flag_q[i] <= 1'b1;
                else if (wb_wr && wb_adr_i == pdmm_pkg::WB_WAKE && wb_sel_i[0]
                         && wb_dat_i[i])
                    wake_flag_q[i] <= 1'b0;
            end
        end
    end

    // wishbone read mux; unmapped addresses answer with zero
    always_comb
    begin
        wb_rdata = 32'h00000000;
        case (wb_adr_i)
            pdmm_pkg::WB_CTRL:   wb_rdata = {30'h0, gie_q};
            pdmm_pkg::WB_STATUS: wb_rdata = {3'h0, sp_q, 3'h0, pc_q};
            pdmm_pkg::WB_WAKE:   wb_rdata = {30'h0, wake_flag_q};
            pdmm_pkg::WB_BANK:   wb_rdata = {28'h0, bank_sel_q};
            default:             wb_rdata = 32'h00000000;
        endcase
    end

    // one wait state: ack a cycle after the strobe, then drop for a cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q    <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end
        else
        begin
            ack_q    <= wb_cyc_i && wb_stb_i && !ack_q;
            wb_dat_q <= wb_rdata;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = wb_dat_q;

endmodule : pdmm_memory_map
`default_nettype wire

// ### pkg/pdmm_pkg.sv
// pdmm_pkg: constants and carriers for the program/data memory map block
package pdmm_pkg;

    // program space
    localparam int PC_W              = 21;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW  = 21'h000018;
    localparam logic [20:0] PC_STEP  = 21'h000002;
    localparam int PROG_KB_SMALL     = 16;
    localparam int PROG_KB_LARGE     = 32;
    localparam logic [15:0] NOP_WORD = 16'h0000;

    // hardware return stack
    localparam int STK_DEPTH         = 31;
    localparam int SP_W              = 5;
    localparam logic [4:0] SP_RESET  = 5'h00;

    // data space
    localparam int DADDR_W           = 12;
    localparam int BANK_COUNT        = 16;
    localparam int BANK_BYTES        = 256;
    localparam int IMPL_BANKS        = 16;
    localparam logic [3:0] BANK_RESET   = 4'h0;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] SFR_BANK     = 4'hF;

    // special function register locations in the top bank
    localparam logic [11:0] SFR_BANK_SEL = 12'hFE0;
    localparam logic [11:0] SFR_STK_PTR  = 12'hFFC;
    localparam logic [11:0] SFR_TOS_LOW  = 12'hFFD;
    localparam logic [11:0] SFR_TOS_HIGH = 12'hFFE;
    localparam logic [11:0] SFR_TOS_UPPR = 12'hFFF;

    // wishbone register byte addresses
    localparam logic [3:0] WB_CTRL   = 4'h0;
    localparam logic [3:0] WB_STATUS = 4'h4;
    localparam logic [3:0] WB_WAKE   = 4'h8;
    localparam logic [3:0] WB_BANK   = 4'hC;
    localparam int CTRL_GIE_H        = 0;
    localparam int CTRL_GIE_L        = 1;
    localparam int WAKE_HIGH         = 0;
    localparam int WAKE_LOW          = 1;
    localparam int STATUS_SP_LSB     = 24;

    // data access request from the core
    typedef struct packed {
        logic        valid;
        logic        we;
        logic        full;    // full 12-bit address, bank selector ignored
        logic        access;  // use the access window
        logic [11:0] addr;    // low 8 bits used unless full
        logic [7:0]  wdata;
    } pdmm_dreq_s;

    // data access answer to the core
    typedef struct packed {
        logic        done;
        logic        hit;     // location implemented
        logic [7:0]  rdata;
    } pdmm_drsp_s;

endpackage : pdmm_pkg

// ### test/pdmm_flash_model.sv
// pdmm_flash_model: program flash on the fetch bus, answering in the same cycle
`timescale 1ns/1ps
`default_nettype none

module pdmm_flash_model (
    input wire logic [19:0] prog_addr,
    output logic     [15:0] prog_rdata
);
    // own fetch bus, never idle
    // flash answers at every address, so any zero fill must come from the block
    always_comb
        prog_rdata = prog_addr[15:0] ^ 16'h5A5A;
endmodule : pdmm_flash_model

`default_nettype wire

// ### test/pdmm_monitor.sv
// pdmm_monitor: port-level assertions for the memory map block
`timescale 1ns/1ps
`default_nettype none

module pdmm_monitor #(
    parameter int PROG_KB = 32
) (
    input wire logic                 mclk,
    input wire logic                 rst_b,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [3:0]           wb_adr_i,
    input wire logic [3:0]           wb_sel_i,
    input wire logic [31:0]          wb_dat_i,
    input wire logic                 wb_ack_o,
    input wire logic                 pc_step,
    input wire logic                 pc_load,
    input wire logic [20:0]          pc_target,
    input wire logic                 stk_pop,
    input wire logic                 wake_irq,
    input wire logic                 wake_high,
    input wire logic [20:0]          pc_q,
    input wire logic [15:0]          prog_rdata,
    input wire logic [19:0]          prog_addr,
    input wire logic [15:0]          instr_q,
    input wire logic                 instr_in_range_q,
    input wire pdmm_pkg::pdmm_dreq_s dreq,
    input wire pdmm_pkg::pdmm_drsp_s drsp_q
);
    localparam logic [20:0] LIMIT = 21'(PROG_KB * 1024);
    logic [1:0] gie_q;
    logic       take;
    logic       en;

    // request taken and wake qualified by the mirrored enables
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign en   = wake_irq && (wake_high ? gie_q[0] : gie_q[1]);

    // mirror of the enables; only lane 0 writes, so sel must gate it too
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            gie_q <= 2'h0;
        else if (take && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0])
            gie_q <= wb_dat_i[1:0];
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_reset_pc_zero: assert property (disable iff (1'b0) !rst_b |=> pc_q == 21'h0)
        else $error("pc not zero in reset");
    a_ack_one_wait: assert property (take |=> wb_ack_o)
        else $error("bus ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held");
    a_data_answer: assert property (dreq.valid |=> drsp_q.done)
        else $error("data access unanswered");
    a_done_cause: assert property (!dreq.valid |=> !drsp_q.done)
        else $error("spurious data done");
    a_fetch_zero: assert property (pc_q >= LIMIT |=> instr_q == 16'h0 && !instr_in_range_q)
        else $error("fetch above memory not zero");
    // the release edge still resets the fetch register, so it starts no attempt
    a_fetch_pass: assert property (rst_b && pc_q < LIMIT
        |=> instr_q == $past(prog_rdata) && instr_in_range_q)
        else $error("fetch word lost");
    a_fetch_addr: assert property (prog_addr == pc_q[20:1])
        else $error("fetch address not from pc");
    a_vec_high: assert property (en && wake_high |=> pc_q == 21'h8)
        else $error("high vector not loaded");
    a_vec_low: assert property (en && !wake_high |=> pc_q == 21'h18)
        else $error("low vector not loaded");
    a_wake_masked: assert property (wake_irq && !en && !pc_load && !stk_pop && !pc_step
        |=> $stable(pc_q))
        else $error("disabled wake moved pc");
    a_step_two: assert property (pc_step && !wake_irq && !pc_load && !stk_pop
        |=> pc_q == $past(pc_q) + 21'h2)
        else $error("pc step wrong");
    a_load_target: assert property (pc_load && !en |=> pc_q == $past(pc_target))
        else $error("pc load wrong");

    c_wake_high: cover property (en && wake_high);
    c_fetch_zero: cover property (pc_q >= LIMIT);
    c_bus_read: cover property (take && !wb_we_i);
endmodule : pdmm_monitor

bind pdmm_memory_map pdmm_monitor #(.PROG_KB(PROG_KB)) mon_u (.mclk, .rst_b, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .pc_step, .pc_load,
    .pc_target, .stk_pop, .wake_irq, .wake_high, .pc_q, .prog_rdata, .prog_addr, .instr_q,
    .instr_in_range_q, .dreq, .drsp_q);

`default_nettype wire

// ### test/tb.sv
// tb: self-checking bench for the program/data memory map block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                 mclk = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 cyc = 1'b0;
    logic                 stb = 1'b0;
    logic                 we = 1'b0;
    logic [3:0]           adr = 4'h0;
    logic [3:0]           sel = 4'h0;
    logic [31:0]          wdat = 32'h0;
    logic [31:0]          rdat;
    logic                 ack;
    logic [4:0]           op = 5'h0;
    logic [20:0]          tgt = 21'h0;
    logic [20:0]          pc;
    logic [15:0]          fw;
    logic [19:0]          fa;
    logic [15:0]          instr;
    logic                 inr;
    pdmm_pkg::pdmm_dreq_s dreq = '0;
    pdmm_pkg::pdmm_drsp_s drsp;
    logic                 hit_seen = 1'b0;
    int                   mismatches = 0;
    int                   checks = 0;
    int                   cycles = 0;

    // op bits: load, step, pop, wake, high
    pdmm_memory_map #(.PROG_KB(32), .SPLIT(8'h60)) dut_u (.mclk(mclk), .rst_b(rst_b),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pc_step(op[3]), .pc_load(op[4]),
        .pc_target(tgt), .stk_pop(op[2]), .wake_irq(op[1]), .wake_high(op[0]), .pc_q(pc),
        .prog_rdata(fw), .prog_addr(fa), .instr_q(instr), .instr_in_range_q(inr),
        .dreq(dreq), .drsp_q(drsp));
    pdmm_flash_model flash_u (.prog_addr(fa), .prog_rdata(fw));

    // free-running clock
    always #25 mclk = ~mclk;

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // classic cycle; no fixed latency assumed, the timeout bounds the wait
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do
            @(posedge mclk);
        while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // one data access; answer sampled the cycle after it is taken
    task automatic dac(input logic w, input logic f, input logic a, input logic [11:0] ad,
                       input logic [7:0] d, output logic [7:0] r);
        @(posedge mclk);
        dreq <= '{valid: 1'b1, we: w, full: f, access: a, addr: ad, wdata: d};
        @(posedge mclk);
        dreq.valid <= 1'b0;
        @(posedge mclk);
        r = drsp.rdata;
        hit_seen = drsp.hit;
        chk("done", 32'(drsp.done), 32'h1);
    endtask : dac

    // one-cycle pc control pulse, then let pc and fetch settle
    task automatic pcop(input logic [4:0] k, input logic [20:0] t);
        @(posedge mclk);
        op <= k;
        tgt <= t;
        @(posedge mclk);
        op <= 5'h0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : pcop

    task automatic s_reset();
        logic [31:0] r;
        chk("pc", 32'(pc), 32'h0);
        wb(1'b0, 4'hC, 32'h0, 4'hF, r);
        chk("bank", r, 32'h0);
        wb(1'b0, 4'h2, 32'h0, 4'hF, r);
        chk("unmapped", r, 32'h0);
    endtask : s_reset

    task automatic s_fetch();
        pcop(5'h10, 21'h007FFE);
        chk("last word", {15'h0, inr, instr}, {15'h0, 1'b1, 16'h3FFF ^ 16'h5A5A});
        pcop(5'h08, 21'h0);
        chk("stepped pc", 32'(pc), 32'h8000);
        chk("zero fill", {15'h0, inr, instr}, 32'h0);
        pcop(5'h10, 21'h1FFFFE);
        chk("top fill", {15'h0, inr, instr}, 32'h0);
    endtask : s_fetch

    task automatic s_wake();
        logic [31:0] r;
        logic [7:0]  d;
        pcop(5'h10, 21'h000100);
        pcop(5'h03, 21'h0);
        chk("masked wake", 32'(pc), 32'h100);
        wb(1'b1, 4'h0, 32'h1, 4'h0, r);
        pcop(5'h03, 21'h0);
        chk("lane off", 32'(pc), 32'h100);
        wb(1'b1, 4'h0, 32'h1, 4'hF, r);
        pcop(5'h03, 21'h0);
        chk("high vec", 32'(pc), 32'h8);
        wb(1'b0, 4'h4, 32'h0, 4'hF, r);
        chk("stack ptr", r, 32'h01000008);
        dac(1'b0, 1'b1, 1'b0, 12'hFFE, 8'h0, d);
        chk("saved pc", 32'(d), 32'h1);
        wb(1'b0, 4'h8, 32'h0, 4'hF, r);
        chk("cause", r, 32'h1);
        wb(1'b1, 4'h8, 32'h1, 4'hF, r);
        wb(1'b0, 4'h8, 32'h0, 4'hF, r);
        chk("cause clr", r, 32'h0);
        wb(1'b1, 4'h0, 32'h2, 4'hF, r);
        pcop(5'h02, 21'h0);
        chk("low vec", 32'(pc), 32'h18);
        pcop(5'h04, 21'h0);
        wb(1'b0, 4'h4, 32'h0, 4'hF, r);
        chk("pop", r, 32'h01000008);
    endtask : s_wake

    task automatic s_data();
        logic [31:0] r;
        logic [7:0]  d;
        dac(1'b1, 1'b1, 1'b0, 12'hFE0, 8'hA7, d);
        dac(1'b0, 1'b1, 1'b0, 12'hFE0, 8'h0, d);
        chk("bank sel", 32'(d), 32'h7);
        wb(1'b0, 4'hC, 32'h0, 4'hF, r);
        chk("bank reg", r, 32'h7);
        dac(1'b1, 1'b0, 1'b0, 12'h055, 8'h3C, d);
        dac(1'b0, 1'b1, 1'b0, 12'h755, 8'h0, d);
        chk("banked", 32'(d), 32'h3C);
        chk("banked hit", 32'(hit_seen), 32'h1);
        dac(1'b1, 1'b0, 1'b1, 12'h010, 8'h99, d);
        dac(1'b0, 1'b1, 1'b0, 12'h010, 8'h0, d);
        chk("access low", 32'(d), 32'h99);
        dac(1'b0, 1'b0, 1'b1, 12'h0E0, 8'h0, d);
        chk("access sfr", 32'(d), 32'h7);
        dac(1'b0, 1'b1, 1'b0, 12'hF80, 8'h0, d);
        chk("empty sfr", 32'(d), 32'h0);
        chk("empty hit", 32'(hit_seen), 32'h0);
    endtask : s_data

    // mid-run reset: pc, bank selector and wake causes go back to zero
    task automatic s_rerst();
        logic [31:0] r;
        pcop(5'h10, 21'h000200);
        @(posedge mclk);
        rst_b <= 1'b0;
        @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        chk("pc again", 32'(pc), 32'h0);
        chk("fetch again", {15'h0, inr, instr}, {15'h0, 1'b1, 16'h0000 ^ 16'h5A5A});
        wb(1'b0, 4'hC, 32'h0, 4'hF, r);
        chk("bank again", r, 32'h0);
        wb(1'b0, 4'h8, 32'h0, 4'hF, r);
        chk("cause again", r, 32'h0);
    endtask : s_rerst

    // cut a hang short; the run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            results();
        end
    end

    // reset, then the scenarios in turn
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        s_reset();
        s_fetch();
        s_wake();
        s_data();
        s_rerst();
        results();
    end
endmodule : tb

`default_nettype wire
